// >>> hw/programmable_stage.sv
// Programmable stage: comparators, blocking, timers, events, counters, log
//
// Implementation choices: the register addresses and the plain strobed port.
module programmable_stage
	import stage_pkg::*;
#(
	parameter int NCH   = NUM_MAG,
	parameter int DEPTH = LOG_DEPTH,
	parameter int TICK  = TICK_CYC
)(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	// Measurements and blocking matrix
	input  wire logic [NCH-1:0][MAG_W-1:0] meas_mag,
	input  wire logic                      block_in,
	input  wire logic [2:0]                setting_group,
	input  wire logic [TIME_W-1:0]         rtc_stamp,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic [31:0]                    reg_rdata,
	// Stage outputs
	output logic                           start_out,
	output logic                           trip_out,
	output logic                           blocked_out,
	output event_s                         event_out,
	output logic                           event_vld
);

	// ****************************************************************
	// Program cycle tick
	// ****************************************************************
	logic [15:0] tick_cnt_r;
	wire         tick = (tick_cnt_r == 16'(TICK - 1));

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 16'h0001;

	// ****************************************************************
	// Settings
	// ****************************************************************
	logic [NCH-1:0]            ch_en_r;
	logic [NCH-1:0][2:0]       mode_r;
	logic [NCH-1:0][MAG_W-1:0] pick_r;
	logic [NCH-1:0][15:0]      hyst_r;
	logic [NCH-1:0][MAG_W-1:0] blim_r;
	logic [TIME_W-1:0]         oper_r;
	logic [TIME_W-1:0]         rel_r;
	logic [5:0]                evsel_r;

	wire wr_ctrl  = reg_wr && reg_addr == A_CTRL;
	wire wr_oper  = reg_wr && reg_addr == A_OPER;
	wire wr_rel   = reg_wr && reg_addr == A_REL;
	wire wr_evsel = reg_wr && reg_addr == A_EVSEL;
	wire cnt_clr  = wr_ctrl && reg_wdata[8];

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			ch_en_r <= NCH'(1);
			oper_r  <= OPER_RST;
			rel_r   <= REL_RST;
			evsel_r <= 6'h3F;
		end
		else
		begin
			if (wr_ctrl)
				ch_en_r <= reg_wdata[NCH-1:0];
			if (wr_oper)
				oper_r <= reg_wdata;
			if (wr_rel)
				rel_r <= reg_wdata;
			if (wr_evsel)
				evsel_r <= reg_wdata[5:0];
		end

	// ****************************************************************
	// Comparators, one per measured input
	// ****************************************************************
	logic [NCH-1:0]            cond_r;
	logic [NCH-1:0][MAG_W-1:0] hist_r [DELTA_TICKS];
	logic [NCH-1:0][MAG_W-1:0] ratio_w;

	genvar g;
	for (g = 0; g < NCH; g++)
	begin : g_ch
		wire [7:0] base = 8'(A_CH_BASE + g * CH_STRIDE);

		always_ff @(posedge sys_clk or posedge rst)
			if (rst)
			begin
				mode_r[g] <= 3'(M_OVER);
				pick_r[g] <= PICK_RST;
				hyst_r[g] <= HYST_RST;
				blim_r[g] <= '0;
			end
			else if (reg_wr)
			begin
				if (reg_addr == base)
					mode_r[g] <= reg_wdata[2:0];
				if (reg_addr == base + 8'h01)
					pick_r[g] <= reg_wdata;
				if (reg_addr == base + 8'h02)
					hyst_r[g] <= reg_wdata[15:0];
				if (reg_addr == base + 8'h03)
					blim_r[g] <= reg_wdata;
			end

		wire signed [MAG_W-1:0] m    = meas_mag[g];
		wire signed [MAG_W-1:0] p    = pick_r[g];
		wire signed [MAG_W-1:0] old  = hist_r[DELTA_TICKS-1][g];
		wire signed [MAG_W-1:0] am   = m[MAG_W-1] ? -m : m;
		wire signed [MAG_W-1:0] ap   = p[MAG_W-1] ? -p : p;
		wire signed [MAG_W-1:0] dlt  = m - old;
		wire signed [MAG_W-1:0] adlt = dlt[MAG_W-1] ? -dlt : dlt;
		wire signed [MAG_W-1:0] aold = old[MAG_W-1] ? -old : old;
		// Hysteresis band scales with the pick-up level; 64-bit avoids overflow
		wire signed [63:0] hprod = 64'(ap) * 64'(hyst_r[g]);
		wire signed [MAG_W-1:0] hb = MAG_W'(hprod / HYST_SCALE);
		// Relative delta: change * 100 against pick-up percent of old value
		wire signed [63:0] rel_l = 64'(dlt) * 64'(100);
		wire signed [63:0] rel_r_ = 64'(p) * 64'(aold);
		wire signed [63:0] arel_l = 64'(adlt) * 64'(100);
		wire signed [63:0] arel_r = 64'(ap) * 64'(aold);
		wire held = cond_r[g];
		logic hit;

		always_comb
		begin
			case (cmp_mode_e'(mode_r[g]))
				M_OVER:      hit = held ? (m > p - hb) : (m > p);
				M_OVER_ABS:  hit = held ? (am > p - hb) : (am > p);
				M_UNDER:     hit = (m >= $signed(blim_r[g])) &&
					(held ? (m < p + hb) : (m < p));
				M_UNDER_ABS: hit = (m >= $signed(blim_r[g])) &&
					(held ? (am < p + hb) : (am < p));
				M_DREL_SGN:  hit = p[MAG_W-1] ? (rel_l < rel_r_) : (rel_l > rel_r_);
				M_DREL_ABS:  hit = arel_l > arel_r;
				M_DVAL_SGN:  hit = p[MAG_W-1] ? (dlt < p) : (dlt > p);
				M_DVAL_ABS:  hit = adlt > ap;
				default:     hit = 1'b0;
			endcase
		end

		assign ratio_w[g] = (p == 0) ? '0 : MAG_W'((64'(m) * 64'(1000)) / 64'(p));

		always_ff @(posedge sys_clk or posedge rst)
			if (rst)
				cond_r[g] <= 1'b0;
			else if (tick)
				cond_r[g] <= hit && ch_en_r[g];
	end

	// History line: one sample per program cycle, 20 ms deep
	always_ff @(posedge sys_clk)
		if (tick)
		begin
			hist_r[0] <= meas_mag;
			for (int i = 1; i < DELTA_TICKS; i++)
				hist_r[i] <= hist_r[i-1];
		end

	wire pickup = |cond_r;

	// ****************************************************************
	// Blocking, start, trip and timers
	// ****************************************************************
	logic              blk_smp_r;
	logic [TIME_W-1:0] op_cnt_r;
	logic [TIME_W-1:0] rel_cnt_r;
	logic              releasing_r;

	// Block is caught first so the same cycle's pick-up sees it
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			blk_smp_r <= 1'b0;
		else if (tick)
			blk_smp_r <= block_in;

	wire start_nxt   = pickup && !blk_smp_r;
	wire blocked_nxt = pickup && blk_smp_r;
	wire op_done     = start_out && op_cnt_r <= 1;

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
			op_cnt_r    <= '0;
			rel_cnt_r   <= '0;
			releasing_r <= 1'b0;
		end
		else if (tick)
		begin
			start_out   <= start_nxt;
			blocked_out <= blocked_nxt;
			if (start_nxt && !start_out)
				op_cnt_r <= oper_r;
			else if (!start_nxt)
				op_cnt_r <= '0;
			else if (op_cnt_r != 0)
				op_cnt_r <= op_cnt_r - 1'b1;
			if (start_nxt && op_done)
				trip_out <= 1'b1;
			if (start_nxt)
				releasing_r <= 1'b0;
			else if (start_out || trip_out)
			begin
				if (!releasing_r)
				begin
					releasing_r <= 1'b1;
					rel_cnt_r   <= rel_r;
				end
				else if (rel_cnt_r <= 1)
				begin
					trip_out    <= 1'b0;
					releasing_r <= 1'b0;
				end
				else
					rel_cnt_r <= rel_cnt_r - 1'b1;
			end
		end

	// ****************************************************************
	// Events, counters and log
	// ****************************************************************
	localparam int PTR_W = $clog2(DEPTH);

	logic [2:0]       prev_r;
	logic [31:0]      cnt_r [3];
	log_s             log_r [DEPTH];
	logic [PTR_W-1:0] wptr_r;

	wire [2:0] cur     = {blocked_out, trip_out, start_out};
	wire [2:0] ev_on   = cur & ~prev_r;
	wire [2:0] ev_off  = ~cur & prev_r;
	wire [2:0] pend    = ev_on | ev_off;
	// One edge is retired per cycle, priority start, trip, block; a filtered edge is
	// retired too, else it would hide every later edge of that output
	wire [1:0] ev_idx  = pend[0] ? 2'd0 : pend[1] ? 2'd1 : 2'd2;
	wire       ev_pend = |pend;
	// Counters and log follow the retired edge, so an edge counts once
	wire       ev_rise = ev_pend && cur[ev_idx];
	wire [2:0] hit_on  = {3{ev_rise}} & (3'b001 << ev_idx);
	wire       ev_any  = evsel_r[{ev_idx, !cur[ev_idx]}];

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			prev_r    <= '0;
			event_vld <= 1'b0;
			event_out <= '0;
			wptr_r    <= '0;
			for (int i = 0; i < 3; i++)
				cnt_r[i] <= '0;
		end
		else
		begin
			event_vld <= 1'b0;
			// Clear-on-write resets counters; an edge in that cycle still counts
			for (int i = 0; i < 3; i++)
				if (hit_on[i])
					cnt_r[i] <= (cnt_clr ? 32'h0 : cnt_r[i]) + 32'h1;
				else if (cnt_clr)
					cnt_r[i] <= '0;
			if (ev_pend)
			begin
				// Retire the chosen edge whether or not it is reported
				prev_r[ev_idx] <= cur[ev_idx];
				if (ev_any)
				begin
					event_vld       <= 1'b1;
					event_out.stamp <= rtc_stamp;
					event_out.id    <= ev_idx;
					event_out.on    <= cur[ev_idx];
				end
			end
			if (ev_rise)
				wptr_r <= (wptr_r == PTR_W'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
		end

	// Log payload; only the first input (channel 0) is recorded, whatever the enables
	always_ff @(posedge sys_clk)
		if (ev_rise)
		begin
			log_r[wptr_r].stamp  <= rtc_stamp;
			log_r[wptr_r].id     <= ev_idx;
			log_r[wptr_r].mag    <= meas_mag[0];
			log_r[wptr_r].ratio  <= ratio_w[0];
			log_r[wptr_r].remain <= op_cnt_r;
			log_r[wptr_r].group  <= setting_group;
		end

	// ****************************************************************
	// Read port
	// ****************************************************************
	wire [7:0] log_off = reg_addr - A_LOG_BASE;
	wire [5:0] log_ix  = 6'(log_off >> 2);
	wire       in_log  = reg_addr >= A_LOG_BASE && log_ix < 6'(DEPTH);
	log_s      log_rd;
	assign log_rd = in_log ? log_r[log_ix[$clog2(DEPTH)-1:0]] : '0;

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		case (reg_addr)
			A_CTRL:      rd_mux = 32'(ch_en_r);
			A_OPER:      rd_mux = oper_r;
			A_REL:       rd_mux = rel_r;
			A_STATUS:    rd_mux = {28'h0, pickup, blocked_out, trip_out, start_out};
			A_REMAIN:    rd_mux = op_cnt_r;
			A_CNT_START: rd_mux = cnt_r[0];
			A_CNT_TRIP:  rd_mux = cnt_r[1];
			A_CNT_BLK:   rd_mux = cnt_r[2];
			A_EVSEL:     rd_mux = 32'(evsel_r);
			A_LOG_PTR:   rd_mux = 32'(wptr_r);
			default:
			begin
				for (int c = 0; c < NCH; c++)
				begin
					if (reg_addr == 8'(A_CH_BASE + c * CH_STRIDE))
						rd_mux = 32'(mode_r[c]);
					if (reg_addr == 8'(A_CH_BASE + c * CH_STRIDE + 1))
						rd_mux = pick_r[c];
					if (reg_addr == 8'(A_CH_BASE + c * CH_STRIDE + 2))
						rd_mux = 32'(hyst_r[c]);
					if (reg_addr == 8'(A_CH_BASE + c * CH_STRIDE + 3))
						rd_mux = blim_r[c];
				end
				if (in_log)
					case (log_off[1:0])
						2'h0:    rd_mux = log_rd.stamp;
						2'h1:    rd_mux = {27'h0, log_rd.group, log_rd.id};
						2'h2:    rd_mux = log_rd.mag;
						default: rd_mux = log_rd.remain;
					endcase
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;

endmodule : programmable_stage

// >>> hw/stage_pkg.sv
// Package: constants and carrier types for the programmable stage comparator
package stage_pkg;

	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int MAG_W          = 32;
	localparam int TIME_W         = 32;
	localparam int NUM_MAG        = 3;
	localparam int LOG_DEPTH      = 12;
	localparam int CLK_HZ         = 50_000_000;
	localparam int TICK_US        = 1000;
	localparam int TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
	localparam int DELTA_MS       = 20;
	localparam int DELTA_TICKS    = DELTA_MS * 1000 / TICK_US;
	localparam int HYST_SCALE     = 10000;
	localparam logic [15:0] HYST_RST       = 16'h012C;
	localparam logic [TIME_W-1:0] OPER_RST = 32'h0000_0028;
	localparam logic [TIME_W-1:0] REL_RST  = 32'h0000_003C;
	localparam logic [MAG_W-1:0]  PICK_RST = 32'h0000_0001;

	// ****************************************************************
	// Register map (word index on the plain port)
	// ****************************************************************
	localparam logic [7:0] A_CTRL      = 8'h00;
	localparam logic [7:0] A_OPER      = 8'h01;
	localparam logic [7:0] A_REL       = 8'h02;
	localparam logic [7:0] A_STATUS    = 8'h03;
	localparam logic [7:0] A_REMAIN    = 8'h04;
	localparam logic [7:0] A_CNT_START = 8'h05;
	localparam logic [7:0] A_CNT_TRIP  = 8'h06;
	localparam logic [7:0] A_CNT_BLK   = 8'h07;
	localparam logic [7:0] A_EVSEL     = 8'h08;
	localparam logic [7:0] A_LOG_PTR   = 8'h09;
	localparam logic [7:0] A_CH_BASE   = 8'h10;
	localparam logic [7:0] A_LOG_BASE  = 8'h40;
	localparam int CH_STRIDE  = 4;
	localparam int LOG_STRIDE = 4;

	typedef enum logic [2:0] {
		M_OVER, M_OVER_ABS, M_UNDER, M_UNDER_ABS,
		M_DREL_SGN, M_DREL_ABS, M_DVAL_SGN, M_DVAL_ABS
	} cmp_mode_e;

	typedef enum logic [1:0] { EV_START, EV_TRIP, EV_BLOCK } ev_id_e;

	typedef struct packed {
		logic [TIME_W-1:0] stamp;
		logic [1:0]        id;
		logic              on;
	} event_s;

	typedef struct packed {
		logic [TIME_W-1:0] stamp;
		logic [1:0]        id;
		logic [MAG_W-1:0]  mag;
		logic [MAG_W-1:0]  ratio;
		logic [TIME_W-1:0] remain;
		logic [2:0]        group;
	} log_s;

endpackage : stage_pkg

// >>> bench/meas_source.sv
// Partner model: measurement subsystem and blocking matrix
module meas_source
	import stage_pkg::*;
#(
	parameter int NCH = NUM_MAG
)(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Wanted values from the bench
	input  wire logic [MAG_W-1:0]     want_mag,
	input  wire logic                 want_blk,
	// Far-side outputs
	output logic [NCH-1:0][MAG_W-1:0] meas_mag,
	output logic                      block_in,
	output logic [TIME_W-1:0]         rtc_stamp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Sources
	// ****************************************
	// Unused channels toggle so a stray enable shows up as noise
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			meas_mag  <= '0;
			block_in  <= 1'b0;
			rtc_stamp <= 32'h0000_0064;
		end
		else
		begin
			meas_mag[0]       <= want_mag;
			meas_mag[NCH-1:1] <= ~meas_mag[NCH-1:1];
			block_in          <= want_blk;
			rtc_stamp         <= rtc_stamp + 32'h0000_0001;
		end
endmodule : meas_source

// >>> bench/programmable_stage_asserts.sv
// Checker: port-level properties of the programmable stage
module stage_asserts
	import stage_pkg::*;
#(
	parameter int NCH   = NUM_MAG,
	parameter int DEPTH = LOG_DEPTH,
	parameter int TICK  = TICK_CYC
)(
	input wire logic                      sys_clk,
	input wire logic                      rst,
	input wire logic [NCH-1:0][MAG_W-1:0] meas_mag,
	input wire logic                      block_in,
	input wire logic [2:0]                setting_group,
	input wire logic [TIME_W-1:0]         rtc_stamp,
	input wire logic [7:0]                reg_addr,
	input wire logic [31:0]               reg_wdata,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [31:0]               reg_rdata,
	input wire logic                      start_out,
	input wire logic                      trip_out,
	input wire logic                      blocked_out,
	input wire event_s                    event_out,
	input wire logic                      event_vld
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Saturates so a long block cannot wrap back under the limit
	logic [15:0] blk_cnt_r;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			blk_cnt_r <= '0;
		else if (!block_in)
			blk_cnt_r <= '0;
		else if (blk_cnt_r != 16'hFFFF)
			blk_cnt_r <= blk_cnt_r + 16'h0001;
	a_start_blk_excl: assert property (!(start_out && blocked_out))
		else $error("start and blocked both high");
	a_trip_with_start: assert property ($rose(trip_out) |-> start_out)
		else $error("trip rose without start");
	a_trip_release: assert property ($fell(trip_out) |-> !start_out && !$past(start_out))
		else $error("trip fell without prior dropout");
	a_start_event: assert property ($rose(start_out) |->
		##[0:4] (event_vld && event_out.id == EV_START && event_out.on))
		else $error("no start on event");
	a_trip_event: assert property ($rose(trip_out) |->
		##[0:4] (event_vld && event_out.id == EV_TRIP && event_out.on))
		else $error("no trip on event");
	a_block_event: assert property ($rose(blocked_out) |->
		##[0:4] (event_vld && event_out.id == EV_BLOCK && event_out.on))
		else $error("no block on event");
	a_block_clears: assert property (blk_cnt_r > 3 * TICK |-> !start_out)
		else $error("start held under block");
	a_event_stamp: assert property (event_vld |->
		event_out.stamp != '0 && event_out.stamp <= rtc_stamp)
		else $error("event stamp out of range");
endmodule : stage_asserts

bind programmable_stage stage_asserts #(.NCH(NCH), .DEPTH(DEPTH), .TICK(TICK)) stage_asserts_i (
	.sys_clk(sys_clk), .rst(rst), .meas_mag(meas_mag), .block_in(block_in),
	.setting_group(setting_group), .rtc_stamp(rtc_stamp), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
	.event_out(event_out), .event_vld(event_vld));

// >>> bench/programmable_stage_test.sv
// Testbench: stage driven through registers and the partner model
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, s); end end
module programmable_stage_test
	import stage_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int TK = 10;
	logic                   sys_clk = 1'b0;
	logic                   rst = 1'b1;
	logic [MAG_W-1:0]       want_mag = '0;
	logic                   want_blk = 1'b0;
	logic [2:0]             setting_group = 3'h5;
	logic [7:0]             reg_addr = '0;
	logic [31:0]            reg_wdata = '0;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic [2:0][MAG_W-1:0]  meas_mag;
	logic                   block_in, start_out, trip_out, blocked_out, event_vld;
	logic [TIME_W-1:0]      rtc_stamp;
	logic [31:0]            reg_rdata;
	event_s                 event_out;
	int                     n_errors = 0;
	int                     comparisons = 0;
	int                     ev_cnt [8] = '{default: 0};
	wire logic [2:0]        outs = {blocked_out, trip_out, start_out};
	int tab [15][5] = '{'{0, 1200, 0, 1500, 0}, '{0, 1200, 0, -1500, 0},
		'{1, 1200, 0, -1500, 0}, '{2, 800, 1000, 500, 0}, '{2, 800, 1000, 500, 600},
		'{3, 800, 1000, 500, 0}, '{3, 800, 1000, 500, 600}, '{4, 10, 1000, 1500, 0},
		'{4, -10, 1000, 500, 0}, '{4, 10, 1000, 500, 0}, '{5, 10, 1000, 500, 0},
		'{5, 10, 1000, 1050, 0}, '{6, 200, 1000, 1300, 0}, '{6, -200, 1000, 1300, 0},
		'{7, 200, 1000, 700, 0}};
	logic [31:0] dft [6][2] = '{'{A_OPER, 32'h28}, '{A_REL, 32'h3C}, '{A_EVSEL, 32'h3F},
		'{A_CH_BASE + 8'h02, 32'h12C}, '{A_CH_BASE + 8'h01, 32'h1}, '{8'h3F, 32'h0}};
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (event_vld === 1'b1)
			ev_cnt[{event_out.id, event_out.on}]++;
	meas_source #(.NCH(3)) meas_source_i (.sys_clk(sys_clk), .rst(rst), .want_mag(want_mag),
		.want_blk(want_blk), .meas_mag(meas_mag), .block_in(block_in), .rtc_stamp(rtc_stamp));
	programmable_stage #(.TICK(TK)) programmable_stage_i (.sys_clk(sys_clk), .rst(rst),
		.meas_mag(meas_mag), .block_in(block_in), .setting_group(setting_group),
		.rtc_stamp(rtc_stamp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out), .trip_out(trip_out),
		.blocked_out(blocked_out), .event_out(event_out), .event_vld(event_vld));
	// ****************************************
	// Tasks and expectations
	// ****************************************
	task automatic give_verdict();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// Outputs only move on ticks, so a wait is bounded in ticks
	task automatic wait_out(input int k, input logic v);
		for (int i = 0; i < 100 * TK && outs[k] !== v; i++)
			@(posedge sys_clk) #1;
		if (outs[k] !== v)
		begin
			n_errors++;
			$display("BAD wait output %0d exp %0b got %0b", k, v, outs[k]);
			give_verdict();
		end
	endtask : wait_out
	function automatic logic exp_cond(input cmp_mode_e m, input int p, o, v, lim);
		int d;
		d = v - o;
		case (m)
			M_OVER:      return v > p;
			M_OVER_ABS:  return (v < 0 ? -v : v) > p;
			M_UNDER:     return v >= lim && v < p;
			M_UNDER_ABS: return v >= lim && (v < 0 ? -v : v) < p;
			M_DREL_SGN:  return p >= 0 ? d * 100 > p * o : d * 100 < p * o;
			M_DREL_ABS:  return (d < 0 ? -d : d) * 100 > p * o;
			M_DVAL_SGN:  return p >= 0 ? d > p : d < p;
			default:     return (d < 0 ? -d : d) > p;
		endcase
	endfunction : exp_cond
	// Channel is disabled while reconfigured so no stale condition leaves hysteresis behind
	task automatic trial(input int m, p, b, v, lim);
		logic [31:0] s;
		wr(A_CTRL, 32'h0);
		wr(A_CH_BASE + 8'h03, lim);
		wr(A_CH_BASE + 8'h01, p);
		wr(A_CH_BASE, m);
		want_mag <= b;
		repeat (5 * TK) @(posedge sys_clk);
		wr(A_CTRL, 32'h1);
		repeat (25 * TK) @(posedge sys_clk);
		rd(A_STATUS, s);
		`CHK("base pickup", exp_cond(cmp_mode_e'(m), p, b, b, lim), s[3])
		want_mag <= v;
		repeat (4 * TK) @(posedge sys_clk);
		rd(A_STATUS, s);
		`CHK("pickup", exp_cond(cmp_mode_e'(m), p, b, v, lim), s[3])
	endtask : trial
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic [31:0] r;
		r = $urandom(17095);
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			rd(dft[i][0], r);
			`CHK("default", dft[i][1], r)
		end
		wr(A_OPER, 32'h3);
		wr(A_REL, 32'h2);
		wr(A_CH_BASE + 8'h01, 32'h3E8);
		wr(A_CTRL, 32'h101);
		rd(A_REMAIN, r);
		`CHK("idle remain", 32'h0, r)
		want_mag <= 32'h44C;
		wait_out(0, 1'b1);
		rd(A_REMAIN, r);
		`CHK("remain range", 1'b1, r != 0 && r <= 3)
		wait_out(1, 1'b1);
		`CHK("start at trip", 1'b1, start_out)
		want_mag <= 32'h3D4;
		repeat (3 * TK) @(posedge sys_clk);
		rd(A_STATUS, r);
		`CHK("held by hysteresis", 1'b1, r[3])
		want_mag <= 32'h3C0;
		wait_out(0, 1'b0);
		`CHK("trip after dropout", 1'b1, trip_out)
		repeat (TK) @(posedge sys_clk);
		#1 `CHK("trip in release", 1'b1, trip_out)
		repeat (TK) @(posedge sys_clk);
		#1 `CHK("trip released", 1'b0, trip_out)
		wait_out(1, 1'b0);
		wr(A_OPER, 32'hA);
		want_mag <= 32'h44C;
		wait_out(0, 1'b1);
		repeat (TK) @(posedge sys_clk);
		want_blk <= 1'b1;
		wait_out(2, 1'b1);
		repeat (12 * TK) @(posedge sys_clk);
		`CHK("trip under block", 1'b0, trip_out)
		want_blk <= 1'b0;
		want_mag <= '0;
		wait_out(2, 1'b0);
		want_blk <= 1'b1;
		repeat (2 * TK) @(posedge sys_clk);
		want_mag <= 32'h44C;
		wait_out(2, 1'b1);
		repeat (4 * TK) @(posedge sys_clk);
		`CHK("start when blocked", 1'b0, start_out)
		want_blk <= 1'b0;
		want_mag <= '0;
		wait_out(2, 1'b0);
		rd(A_CNT_START, r);
		`CHK("start count", 32'h2, r)
		rd(A_CNT_TRIP, r);
		`CHK("trip count", 32'h1, r)
		rd(A_CNT_BLK, r);
		`CHK("block count", 32'h2, r)
		rd(A_LOG_PTR, r);
		`CHK("log ptr", 32'h5, r)
		for (int i = 0; i < 4; i++)
		begin
			rd(A_LOG_BASE + 8'(4 * i + 1), r);
			`CHK("log id", {setting_group, i == 3 ? 2'h2 : i[1:0] == 2'h1 ? 2'h1 : 2'h0}, r[4:0])
		end
		rd(A_LOG_BASE + 8'h02, r);
		`CHK("log mag", 32'h44C, r)
		rd(A_LOG_BASE + 8'h03, r);
		`CHK("log start remain", 32'h3, r)
		rd(A_LOG_BASE + 8'h07, r);
		`CHK("log trip remain", 32'h0, r)
		`CHK("start off events", 2, ev_cnt[0])
		wr(A_EVSEL, 32'h3D);
		for (int i = 0; i < 15; i++)
			trial(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
		for (int i = 0; i < 4; i++)
			trial($urandom % 2, 1100 + $urandom % 2000, 0, int'($urandom % 8000) - 4000, 0);
		`CHK("start off filtered", 2, ev_cnt[0])
		`CHK("start on kept", 1'b1, ev_cnt[1] > 2)
		give_verdict();
	end
endmodule : programmable_stage_test
